// File: logic/scc_pkg.sv
package scc_pkg;

  // -------------------------------------------------------------------------
  // register bus
  // -------------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 16;

  localparam logic [7:0] OFS_CLK_RATIO   = 8'h0A;
  localparam logic [7:0] OFS_RATE_DIV    = 8'h12;
  localparam logic [7:0] OFS_AVG_CTRL    = 8'h15;
  localparam logic [7:0] OFS_PIN_CFG     = 8'h4F;
  localparam logic [7:0] OFS_PIN_OUT_CAL = 8'h50;
  localparam logic [7:0] OFS_HOLD_CLK    = 8'h5F;
  localparam logic [7:0] OFS_DATA_BUF    = 8'h60;
  localparam logic [7:0] OFS_AVG_FIRST   = 8'h64;
  localparam logic [7:0] OFS_AVG_LAST    = 8'h6B;
  localparam logic [7:0] OFS_SUM_FIRST   = 8'h70;
  localparam logic [7:0] OFS_SUM_LAST    = 8'h7F;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [15:0] RST_RATE_DIV    = 16'h0028;
  localparam logic [15:0] RST_AVG_CTRL    = 16'h0600;
  localparam logic [15:0] RST_PIN_CFG     = 16'h2090;
  localparam logic [15:0] RST_PIN_OUT_CAL = 16'h0000;
  localparam logic [15:0] RST_HOLD_CLK    = 16'h0000;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int unsigned BIT_PIN_A_IE     = 1;
  localparam int unsigned BIT_SYNC_LSB     = 2;
  localparam int unsigned BIT_PIN_B_IE     = 5;
  localparam int unsigned BIT_PIN_B_OE     = 6;
  localparam int unsigned BIT_PIN_B_SEL    = 6;
  localparam int unsigned BIT_CAL_START    = 5;
  localparam int unsigned BIT_FAST_RUN     = 0;
  localparam int unsigned BIT_HOLD_FIRST   = 1;
  localparam int unsigned BIT_HOLD_SECOND  = 2;
  localparam int unsigned AVG_FIRST_LSB    = 4;
  localparam int unsigned AVG_SECOND_LSB   = 8;
  localparam int unsigned AVG_CODE_W       = 3;

  // -------------------------------------------------------------------------
  // clocks and timing
  // -------------------------------------------------------------------------
  localparam int unsigned SLOW_CLK_KHZ  = 32;
  localparam int unsigned FAST_CLK_MHZ  = 32;
  localparam int unsigned RATE_MULT     = 4;
  localparam int unsigned RATE_CNT_W    = 18;
  localparam int unsigned RATIO_W       = 12;

  typedef enum logic [1:0] {
    SCC_SYNC_INTERNAL = 2'b00,
    SCC_SYNC_PIN_A    = 2'b01,
    SCC_SYNC_PIN_B    = 2'b10,
    SCC_SYNC_RESERVED = 2'b11
  } scc_sync_t;

  // gray along idle -> arm -> count; count -> idle flips both bits
  typedef enum logic [1:0] {
    SCC_CAL_IDLE  = 2'b00,
    SCC_CAL_ARM   = 2'b01,
    SCC_CAL_COUNT = 2'b11
  } scc_cal_t;

endpackage : scc_pkg

// File: logic/scc_slot_avg.sv
`timescale 1ns/1ps
module scc_slot_avg #(
  parameter int unsigned CH     = 4,
  parameter int unsigned DW     = 16,
  parameter int unsigned SW     = 23
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  // samples in
  input  wire logic                      sample_valid,
  input  wire logic [CH*DW-1:0]          sample_data,
  input  wire logic [2:0]                avg_code,
  // group result
  output logic                           done_q,
  output logic [CH*SW-1:0]               sum_q,
  output logic [CH*DW-1:0]               avg_q
);
  import scc_pkg::*;

  logic [7:0]        cnt_q, cnt_d;
  logic              done_d;
  logic [CH*SW-1:0]  acc_q, acc_d, sum_d;
  logic [CH*DW-1:0]  avg_d;
  logic [7:0]        last_cnt;

  // code n sums 2**n samples
  assign last_cnt = 8'((9'h001 << avg_code) - 9'h001);

  always_comb begin
    cnt_d  = cnt_q;
    acc_d  = acc_q;
    sum_d  = sum_q;
    avg_d  = avg_q;
    done_d = 1'b0;
    if (sample_valid) begin
      for (int c = 0; c < CH; c++) begin
        acc_d[c*SW +: SW] = acc_q[c*SW +: SW] + SW'(sample_data[c*DW +: DW]);
      end
      if (cnt_q >= last_cnt) begin
        // one result per group: output rate decimated by the factor
        done_d = 1'b1;
        sum_d  = acc_d;
        for (int c = 0; c < CH; c++) begin
          avg_d[c*DW +: DW] = DW'(acc_d[c*SW +: SW] >> avg_code);
        end
        acc_d = '0;
        cnt_d = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 8'h00;
      acc_q  <= '0;
      sum_q  <= '0;
      avg_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      acc_q  <= acc_d;
      sum_q  <= sum_d;
      avg_q  <= avg_d;
      done_q <= done_d;
    end
  end

endmodule : scc_slot_avg

// File: logic/scc_regs.sv
// How it works
// - Pin A input buffer enabled only while its config bit 1 is set; resets off.
// - Pin B output, when enabled, drives low or the front-end power-down level.
// - Changing calibration start from 0 to 1 measures fast-clock ratio into register 0x0A.
// - Fast calibration clock runs only while the run enable bit is 1.
// - Second-slot hold bit freezes all second-slot data registers.
// - First-slot hold bit freezes all first-slot data registers.
// - Sample trigger every four times divider slow-clock ticks; divider resets 0x0028.
// - Second-slot factor code in bits 10:8 picks samples summed; resets to 6.
// - Sample sums are readable at 0x70 through 0x7F.
// - Averages are readable at 0x64 through 0x6B and the buffer at 0x60.
// - Average is sum divided by factor, always fitting sixteen bits.
// - One result per group of summed samples, decimating the data rate.
// - First-slot factor in bits 6:4 behaves like the second-slot one.
// - Trigger source: slow-clock divider, pin A, pin B; code 3 reserved.
`timescale 1ns/1ps
module scc_regs #(
  parameter int unsigned CH = 4,
  parameter int unsigned SW = 23
) (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  // register port
  input  wire logic [scc_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [scc_pkg::DATA_W-1:0]        reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic [scc_pkg::DATA_W-1:0]             reg_rdata_q,
  // timing ticks
  input  wire logic                              slow_clk_tick,
  input  wire logic                              fast_clk_tick,
  // pins
  input  wire logic                              pin_a_in,
  input  wire logic                              pin_b_in,
  input  wire logic                              afe_power_down,
  output logic                                   pin_a_input_enable_q,
  output logic                                   pin_b_input_enable_q,
  output logic                                   pin_b_output_enable_q,
  output logic                                   pin_b_out_q,
  // front end
  output logic                                   fast_clock_run_enable_q,
  output logic                                   sample_trigger_q,
  input  wire logic                              sample_valid,
  input  wire logic                              sample_slot,
  input  wire logic [CH*scc_pkg::DATA_W-1:0]     sample_data
);
  import scc_pkg::*;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  logic [15:0] rate_div_q, rate_div_d;
  logic [15:0] avg_ctrl_q, avg_ctrl_d;
  logic [15:0] pin_cfg_q, pin_cfg_d;
  logic [15:0] pin_cal_q, pin_cal_d;
  logic [15:0] hold_clk_q, hold_clk_d;
  logic        cal_start;

  always_comb begin
    rate_div_d = rate_div_q;
    avg_ctrl_d = avg_ctrl_q;
    pin_cfg_d  = pin_cfg_q;
    pin_cal_d  = pin_cal_q;
    hold_clk_d = hold_clk_q;
    cal_start  = 1'b0;
    if (reg_wr) begin
      if (hit(reg_addr, OFS_RATE_DIV)) begin
        rate_div_d = reg_wdata;
      end else if (hit(reg_addr, OFS_AVG_CTRL)) begin
        avg_ctrl_d = reg_wdata;
      end else if (hit(reg_addr, OFS_PIN_CFG)) begin
        pin_cfg_d = reg_wdata;
      end else if (hit(reg_addr, OFS_PIN_OUT_CAL)) begin
        pin_cal_d = reg_wdata;
        // start only on a 0 to 1 change of the start bit
        cal_start = reg_wdata[BIT_CAL_START] && !pin_cal_q[BIT_CAL_START];
      end else if (hit(reg_addr, OFS_HOLD_CLK)) begin
        hold_clk_d = reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_div_q <= RST_RATE_DIV;
      avg_ctrl_q <= RST_AVG_CTRL;
      pin_cfg_q  <= RST_PIN_CFG;
      pin_cal_q  <= RST_PIN_OUT_CAL;
      hold_clk_q <= RST_HOLD_CLK;
    end else begin
      rate_div_q <= rate_div_d;
      avg_ctrl_q <= avg_ctrl_d;
      pin_cfg_q  <= pin_cfg_d;
      pin_cal_q  <= pin_cal_d;
      hold_clk_q <= hold_clk_d;
    end
  end

  // --------------------------------------------------------------------------
  // pins and sample trigger
  // --------------------------------------------------------------------------
  scc_sync_t              sync_sel;
  logic [RATE_CNT_W-1:0]  rate_cnt_q, rate_cnt_d, rate_last;
  logic                   pin_a_q, pin_a_d, pin_b_q, pin_b_d;
  logic                   trig_d, pa_ie_d, pb_ie_d, pb_oe_d, pb_out_d, run_d;

  assign sync_sel  = scc_sync_t'(pin_cfg_q[BIT_SYNC_LSB +: 2]);
  assign rate_last = RATE_CNT_W'(RATE_MULT) * RATE_CNT_W'(rate_div_q) - RATE_CNT_W'(1);

  always_comb begin
    pa_ie_d  = pin_cfg_q[BIT_PIN_A_IE];
    pb_ie_d  = pin_cfg_q[BIT_PIN_B_IE];
    pb_oe_d  = pin_cfg_q[BIT_PIN_B_OE];
    pb_out_d = pin_cal_q[BIT_PIN_B_SEL] ? afe_power_down : 1'b0;
    run_d    = hold_clk_q[BIT_FAST_RUN];
    // buffers disabled read as low
    pin_a_d    = pin_a_in && pin_a_input_enable_q;
    pin_b_d    = pin_b_in && pin_b_input_enable_q;
    rate_cnt_d = rate_cnt_q;
    trig_d     = 1'b0;
    case (sync_sel)
      SCC_SYNC_INTERNAL: begin
        if (slow_clk_tick && rate_div_q != 16'h0000) begin
          if (rate_cnt_q >= rate_last) begin
            rate_cnt_d = '0;
            trig_d     = 1'b1;
          end else begin
            rate_cnt_d = rate_cnt_q + RATE_CNT_W'(1);
          end
        end
      end
      SCC_SYNC_PIN_A: begin
        trig_d = pin_a_d && !pin_a_q;
      end
      SCC_SYNC_PIN_B: begin
        trig_d = pin_b_d && !pin_b_q;
      end
      default: begin
        trig_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_a_input_enable_q    <= 1'b0;
      pin_b_input_enable_q    <= 1'b0;
      pin_b_output_enable_q   <= 1'b0;
      pin_b_out_q             <= 1'b0;
      fast_clock_run_enable_q <= 1'b0;
      sample_trigger_q        <= 1'b0;
      rate_cnt_q              <= '0;
      pin_a_q                 <= 1'b0;
      pin_b_q                 <= 1'b0;
    end else begin
      pin_a_input_enable_q    <= pa_ie_d;
      pin_b_input_enable_q    <= pb_ie_d;
      pin_b_output_enable_q   <= pb_oe_d;
      pin_b_out_q             <= pb_out_d;
      fast_clock_run_enable_q <= run_d;
      sample_trigger_q        <= trig_d;
      rate_cnt_q              <= rate_cnt_d;
      pin_a_q                 <= pin_a_d;
      pin_b_q                 <= pin_b_d;
    end
  end

  // --------------------------------------------------------------------------
  // fast clock ratio measurement
  // --------------------------------------------------------------------------
  scc_cal_t            cal_q, cal_d;
  logic [RATIO_W-1:0]  cnt_q, cnt_d, ratio_q, ratio_d;

  always_comb begin
    cal_d   = cal_q;
    cnt_d   = cnt_q;
    ratio_d = ratio_q;
    case (cal_q)
      SCC_CAL_IDLE: begin
        if (cal_start) begin
          cal_d = SCC_CAL_ARM;
        end
      end
      SCC_CAL_ARM: begin
        if (slow_clk_tick) begin
          cnt_d = '0;
          cal_d = SCC_CAL_COUNT;
        end
      end
      SCC_CAL_COUNT: begin
        // fast ticks per slow period, counted only while the fast clock runs
        if (fast_clk_tick && fast_clock_run_enable_q && cnt_q != '1) begin
          cnt_d = cnt_q + RATIO_W'(1);
        end
        if (slow_clk_tick) begin
          ratio_d = cnt_q;
          cal_d   = SCC_CAL_IDLE;
        end
      end
      default: begin
        cal_d = SCC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_q   <= SCC_CAL_IDLE;
      cnt_q   <= '0;
      ratio_q <= '0;
    end else begin
      cal_q   <= cal_d;
      cnt_q   <= cnt_d;
      ratio_q <= ratio_d;
    end
  end

  // --------------------------------------------------------------------------
  // per-slot summing and held data registers
  // --------------------------------------------------------------------------
  logic [1:0]             grp_done;
  logic [CH*SW-1:0]       grp_sum [2];
  logic [CH*DATA_W-1:0]   grp_avg [2];
  logic [CH*SW-1:0]       sum_q [2], sum_d [2];
  logic [CH*DATA_W-1:0]   avg_q [2], avg_d [2];
  logic [15:0]            buf_q, buf_d;
  logic [1:0]             hold;

  assign hold = {hold_clk_q[BIT_HOLD_SECOND], hold_clk_q[BIT_HOLD_FIRST]};

  for (genvar s = 0; s < 2; s++) begin : g_slot
    scc_slot_avg #(
      .CH (CH),
      .DW (DATA_W),
      .SW (SW)
    ) u_avg (
      .ref_clk      (ref_clk),
      .reset_n      (reset_n),
      .sample_valid (sample_valid && (sample_slot == 1'(s))),
      .sample_data  (sample_data),
      .avg_code     (avg_ctrl_q[(s == 0 ? AVG_FIRST_LSB : AVG_SECOND_LSB) +: AVG_CODE_W]),
      .done_q       (grp_done[s]),
      .sum_q        (grp_sum[s]),
      .avg_q        (grp_avg[s])
    );
  end

  always_comb begin
    buf_d = buf_q;
    for (int s = 0; s < 2; s++) begin
      sum_d[s] = sum_q[s];
      avg_d[s] = avg_q[s];
      if (grp_done[s] && !hold[s]) begin
        sum_d[s] = grp_sum[s];
        avg_d[s] = grp_avg[s];
        buf_d    = grp_avg[s][DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sum_q[0] <= '0;
      sum_q[1] <= '0;
      avg_q[0] <= '0;
      avg_q[1] <= '0;
      buf_q    <= 16'h0000;
    end else begin
      sum_q[0] <= sum_d[0];
      sum_q[1] <= sum_d[1];
      avg_q[0] <= avg_d[0];
      avg_q[1] <= avg_d[1];
      buf_q    <= buf_d;
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  logic [15:0] rdata_d;
  logic [7:0]  rel;
  logic [31:0] sum_word;

  always_comb begin
    rdata_d  = reg_rdata_q;
    rel      = 8'h00;
    sum_word = 32'h0000_0000;
    if (reg_rd) begin
      if (hit(reg_addr, OFS_CLK_RATIO)) begin
        rdata_d = 16'(ratio_q);
      end else if (hit(reg_addr, OFS_RATE_DIV)) begin
        rdata_d = rate_div_q;
      end else if (hit(reg_addr, OFS_AVG_CTRL)) begin
        rdata_d = avg_ctrl_q;
      end else if (hit(reg_addr, OFS_PIN_CFG)) begin
        rdata_d = pin_cfg_q;
      end else if (hit(reg_addr, OFS_PIN_OUT_CAL)) begin
        rdata_d = pin_cal_q;
      end else if (hit(reg_addr, OFS_HOLD_CLK)) begin
        rdata_d = hold_clk_q;
      end else if (hit(reg_addr, OFS_DATA_BUF)) begin
        rdata_d = buf_q;
      end else if (reg_addr >= OFS_AVG_FIRST && reg_addr <= OFS_AVG_LAST) begin
        rel     = reg_addr - OFS_AVG_FIRST;
        rdata_d = avg_q[rel[2]][rel[1:0]*DATA_W +: DATA_W];
      end else if (reg_addr >= OFS_SUM_FIRST && reg_addr <= OFS_SUM_LAST) begin
        // per slot: channel words low then high
        rel      = reg_addr - OFS_SUM_FIRST;
        sum_word = 32'(sum_q[rel[3]][rel[2:1]*SW +: SW]);
        rdata_d  = rel[0] ? sum_word[31:16] : sum_word[15:0];
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule : scc_regs

// File: sim/scc_regs_props.sv
`timescale 1ns/1ps
module scc_regs_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_q,
  // ticks and pins
  input wire logic        slow_clk_tick,
  input wire logic        pin_a_in,
  input wire logic        pin_b_in,
  input wire logic        afe_power_down,
  input wire logic        pin_a_input_enable_q,
  input wire logic        pin_b_output_enable_q,
  input wire logic        pin_b_out_q,
  input wire logic        fast_clock_run_enable_q,
  input wire logic        sample_trigger_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // write followed by two quiet cycles, so the output has settled
  sequence s_wr_quiet(logic [7:0] ofs);
    reg_wr && reg_addr == ofs ##1 !reg_wr ##1 !reg_wr;
  endsequence

  a_pin_a_follow: assert property (s_wr_quiet(8'h4F) |=> pin_a_input_enable_q == $past(reg_wdata[1], 3))
    else $error("pin a input enable does not follow config");
  a_pin_b_oe: assert property (s_wr_quiet(8'h4F) |=> pin_b_output_enable_q == $past(reg_wdata[6], 3))
    else $error("pin b output enable does not follow config");
  a_pin_b_source: assert property (pin_b_out_q |-> $past(afe_power_down))
    else $error("pin b high without power-down level");
  a_fast_follow: assert property (s_wr_quiet(8'h5F) |=> fast_clock_run_enable_q == $past(reg_wdata[0], 3))
    else $error("fast clock enable does not follow register");
  a_fast_cause: assert property ($changed(fast_clock_run_enable_q) |->
      $past(reg_wr && reg_addr == 8'h5F) || $past(reg_wr && reg_addr == 8'h5F, 2))
    else $error("fast clock enable changed without a write");
  a_ratio_fit: assert property (reg_rd && reg_addr == 8'h0A |=> reg_rdata_q[15:12] == 4'h0)
    else $error("clock ratio upper bits not zero");
  a_sum_high: assert property (reg_rd && reg_addr[7:4] == 4'h7 && reg_addr[0] |=>
      reg_rdata_q[15:7] == 9'h000)
    else $error("sum high word wider than seven bits");
  a_trig_pulse: assert property (sample_trigger_q |=> !sample_trigger_q)
    else $error("sample trigger longer than one cycle");
  a_trig_cause: assert property (sample_trigger_q |-> $past(slow_clk_tick) ||
      ($past(pin_a_in) && !$past(pin_a_in, 2)) || ($past(pin_b_in) && !$past(pin_b_in, 2)))
    else $error("sample trigger without a cause");
endmodule : scc_regs_props

bind scc_regs scc_regs_props scc_regs_props_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .slow_clk_tick(slow_clk_tick),
  .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .afe_power_down(afe_power_down),
  .pin_a_input_enable_q(pin_a_input_enable_q), .pin_b_output_enable_q(pin_b_output_enable_q),
  .pin_b_out_q(pin_b_out_q), .fast_clock_run_enable_q(fast_clock_run_enable_q),
  .sample_trigger_q(sample_trigger_q)
);

// File: sim/tb_scc_regs.sv
`timescale 1ns/1ps
module tb_scc_regs;
  import scc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, slow_clk_tick = 1'b0, fast_clk_tick = 1'b0;
  logic        pin_a_in = 1'b0, pin_b_in = 1'b0, afe_power_down = 1'b0;
  logic        sample_valid = 1'b0, sample_slot = 1'b0;
  logic [63:0] sample_data = 64'h0;
  logic [15:0] reg_rdata_q, v;
  logic        pin_a_input_enable_q, pin_b_input_enable_q, pin_b_output_enable_q, pin_b_out_q;
  logic        fast_clock_run_enable_q, sample_trigger_q;
  logic [22:0] sum;
  logic [15:0] last [2] = '{16'h0000, 16'h0000};
  logic [15:0] cfgs [4] = '{16'h2092, 16'h2096, 16'h20B8, 16'h20BE};
  int          nfast [4] = '{25, 16, 7, 7};
  int          nexp [4] = '{25, 25, 0, 7};
  int          errors = 0, compares = 0, trigs = 0, c0;

  scc_regs #(.CH(4), .SW(23)) scc_regs_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .slow_clk_tick(slow_clk_tick),
    .fast_clk_tick(fast_clk_tick), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
    .afe_power_down(afe_power_down), .pin_a_input_enable_q(pin_a_input_enable_q),
    .pin_b_input_enable_q(pin_b_input_enable_q), .pin_b_output_enable_q(pin_b_output_enable_q),
    .pin_b_out_q(pin_b_out_q), .fast_clock_run_enable_q(fast_clock_run_enable_q),
    .sample_trigger_q(sample_trigger_q), .sample_valid(sample_valid), .sample_slot(sample_slot),
    .sample_data(sample_data)
  );

  initial forever #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (sample_trigger_q === 1'b1) trigs++;
  end

  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    idle(3);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask : rd_chk

  // sel 0 slow tick, 1 fast tick, 2 pin a, 3 pin b; held high n cycles
  task automatic drive(input int sel, input int n);
    @(posedge ref_clk);
    case (sel)
      0: slow_clk_tick <= 1'b1;
      1: fast_clk_tick <= 1'b1;
      2: pin_a_in <= 1'b1;
      default: pin_b_in <= 1'b1;
    endcase
    repeat (n) @(posedge ref_clk);
    {slow_clk_tick, fast_clk_tick, pin_a_in, pin_b_in} <= 4'h0;
    idle(3);
  endtask : drive

  task automatic send(input logic s, input logic [15:0] d, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample_slot <= s;
      sample_data <= {4{d}};
      @(posedge ref_clk);
      sample_valid <= 1'b0;
    end
    idle(3);
  endtask : send

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #250_000;
    errors++;
    print_verdict();
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(2);
    check(pin_a_input_enable_q, 1'b0);
    check(fast_clock_run_enable_q, 1'b0);
    check(pin_b_output_enable_q, 1'b0);
    rd_chk(OFS_RATE_DIV, 16'h0028);
    rd_chk(OFS_AVG_CTRL, 16'h0600);
    rd_chk(OFS_PIN_CFG, 16'h2090);
    rd_chk(OFS_PIN_OUT_CAL, 16'h0000);
    rd_chk(OFS_HOLD_CLK, 16'h0000);
    rd_chk(OFS_CLK_RATIO, 16'h0000);
    rd_chk(OFS_SUM_FIRST, 16'h0000);
    wr(OFS_RATE_DIV, 16'h0001);
    repeat (3) drive(0, 1);
    check(23'(trigs), 23'h0);
    drive(0, 1);
    check(23'(trigs), 23'h1);
    repeat (4) drive(0, 1);
    check(23'(trigs), 23'h2);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PIN_CFG, cfgs[i]);
      check(pin_b_input_enable_q, cfgs[i][BIT_PIN_B_IE]);
      for (int j = 0; j < 3; j++) begin
        c0 = trigs;
        drive(j == 0 ? 0 : j + 1, 4);
        check(23'(trigs - c0), 23'(i == j));
      end
    end
    wr(OFS_PIN_CFG, 16'h20D2);
    check(pin_b_output_enable_q, 1'b1);
    check(pin_a_input_enable_q, 1'b1);
    wr(OFS_PIN_OUT_CAL, 16'h0040);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      afe_power_down <= k[0];
      idle(3);
      check(pin_b_out_q, k[0]);
    end
    wr(OFS_PIN_OUT_CAL, 16'h0000);
    check(pin_b_out_q, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_HOLD_CLK, 16'(k != 2));
      check(fast_clock_run_enable_q, k != 2);
      if (k != 1) wr(OFS_PIN_OUT_CAL, 16'h0000);
      wr(OFS_PIN_OUT_CAL, 16'h0020);
      drive(0, 1);
      drive(1, nfast[k]);
      drive(0, 1);
      rd_chk(OFS_CLK_RATIO, 16'(nexp[k]));
    end
    wr(OFS_HOLD_CLK, 16'h0000);
    check(fast_clock_run_enable_q, 1'b0);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        v = 16'hFFF0 - 16'(k * 3) - 16'(s * 32);
        sum = 23'(v) << k;
        wr(OFS_AVG_CTRL, 16'(k) << (s ? 8 : 4));
        if (k > 0) begin
          send(s[0], v, (1 << k) - 1);
          rd_chk(OFS_AVG_FIRST + 8'(s * 4), last[s]);
        end
        send(s[0], v, 1);
        rd_chk(OFS_SUM_FIRST + 8'(s * 8), sum[15:0]);
        rd_chk(OFS_SUM_FIRST + 8'(s * 8 + 1), {9'h000, sum[22:16]});
        rd_chk(OFS_AVG_FIRST + 8'(s * 4), v);
        rd_chk(OFS_DATA_BUF, v);
        last[s] = v;
      end
    end
    wr(OFS_AVG_CTRL, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_HOLD_CLK, 16'(2 << s));
      send(s[0], 16'h1234, 1);
      send(!s[0], 16'h4321, 1);
      rd_chk(OFS_AVG_FIRST + 8'(s * 4), last[s]);
      rd_chk(OFS_AVG_FIRST + 8'(4 - s * 4), 16'h4321);
      last[1 - s] = 16'h4321;
      wr(OFS_HOLD_CLK, 16'h0000);
      send(s[0], 16'h5678, 1);
      rd_chk(OFS_AVG_FIRST + 8'(s * 4), 16'h5678);
    end
    print_verdict();
  end
endmodule : tb_scc_regs
